// file: logic/upkf_pkg.sv
// Purpose: shared constants, types and helpers of the uart packet framer
// Assumes: 40 MHz ref_clk on both ends of the link
// Notes:   crc helper is one byte step of the 16-bit ccitt code
`default_nettype none
package upkf_pkg;
   localparam int unsigned CLK_HZ      = 40_000_000;
   localparam int unsigned TIMEOUT_S   = 4;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;

   typedef enum logic [1:0] {
      UPKF_B38400, UPKF_B57600, UPKF_B115200, UPKF_B230400
   } upkf_baud_e;
   localparam upkf_baud_e BAUD_RST = UPKF_B115200;

   // bit period in ref_clk cycles, rounded to nearest
   localparam logic [10:0] DIV_38400  = 11'((CLK_HZ + 19200) / 38400);
   localparam logic [10:0] DIV_57600  = 11'((CLK_HZ + 28800) / 57600);
   localparam logic [10:0] DIV_115200 = 11'((CLK_HZ + 57600) / 115200);
   localparam logic [10:0] DIV_230400 = 11'((CLK_HZ + 115200) / 230400);

   localparam logic [3:0]  STOP_BIT   = 4'h9;
   localparam logic [9:0]  LINE_IDLE  = 10'h3FF;
   localparam logic [1:0]  SYNC_IDLE  = 2'h3;
   localparam logic [7:0]  PRE_BYTE   = 8'h55;
   localparam logic [15:0] PING_TYPE  = 16'h504B;
   localparam logic [15:0] CRC_POLY   = 16'h1021;
   localparam logic [15:0] CRC_INIT   = 16'hFFFF;
   localparam logic [15:0] GAP_BITS   = 16'h0014;

   typedef enum logic [3:0] {
      RX_HUNT, RX_PRE2, RX_TYP1, RX_TYP2, RX_LEN, RX_PAY, RX_CRC1,
      RX_CRC2, RX_PING_LO
   } upkf_rx_e;

   typedef enum logic [3:0] {
      TX_IDLE, TX_PRE1, TX_PRE2, TX_TYP1, TX_TYP2, TX_LEN, TX_PAY,
      TX_CRC1, TX_CRC2
   } upkf_tx_e;

   function automatic logic [15:0] upkf_crc(input logic [15:0] c,
                                            input logic [7:0]  b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
      end
      return r;
   endfunction

   function automatic logic [10:0] upkf_div(input upkf_baud_e s);
      case (s)
         UPKF_B38400: return DIV_38400;
         UPKF_B57600: return DIV_57600;
         UPKF_B230400: return DIV_230400;
         default: return DIV_115200;
      endcase
   endfunction
endpackage
`default_nettype wire

// file: logic/upkf_if.sv
// Purpose: the two serial lines between host and device
// Assumes: both ends on one ref_clk in simulation
// Notes:   lines idle high
`timescale 1ns/100ps
`default_nettype none
interface upkf_if;
   logic h2d;
   logic d2h;
   modport dev  (input h2d, output d2h);
   modport host (output h2d, input d2h);
endinterface
`default_nettype wire

// file: logic/upkf_dev.sv
// Purpose: device end of the uart packet framer
// Assumes: user logic on ref_clk; pl_byte answers pl_idx combinationally
// Notes:   payload of the last packet received, good crc or bad, is read back through rd_addr
// Functional notes
// - 8N1 characters, no flow control
// - 38400 to 230400 baud, reset at 115200
// - packets start with 0x55 0x55 preamble
// - multi-byte fields go most significant first
// - preamble, type, length, payload, crc in order
// - crc covers all bytes but preamble, crc
// - bad crc packet dropped, no reply
// - whole packet must arrive within four seconds
// - bare preamble plus ping type answered
// - full zero-length ping with good crc answered
// - ccitt crc, poly 1021, init FFFF, no xor
// - length counts payload bytes only, 0 to 255
`timescale 1ns/100ps
`default_nettype none
module upkf_dev #(
   parameter int unsigned TMO_CYC = upkf_pkg::TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   // serial link
   upkf_if.dev                       lnk,
   // line rate
   input  wire upkf_pkg::upkf_baud_e baud_sel,
   input  wire logic                 baud_ld,
   // received packets
   output logic                      rx_done,
   output logic [15:0]               rx_type,
   output logic [7:0]                rx_len,
   input  wire logic [7:0]           rd_addr,
   output logic [7:0]                rd_data,
   // packets to send
   input  wire logic                 tx_req,
   input  wire logic [15:0]          tx_type,
   input  wire logic [7:0]           tx_len,
   output logic                      tx_busy,
   output logic [7:0]                pl_idx,
   input  wire logic [7:0]           pl_byte
);
   import upkf_pkg::*;

   typedef struct packed {
      logic [1:0]  sync;
      upkf_baud_e  baud;
      logic        rbusy;
      logic [3:0]  rbit;
      logic [10:0] rcnt;
      logic [7:0]  rsh;
      upkf_rx_e    pst;
      logic [15:0] typ;
      logic [7:0]  len;
      logic [7:0]  idx;
      logic [15:0] crc;
      logic [7:0]  crc_hi;
      logic [27:0] tmo;
      logic [15:0] gap;
      logic        ping_s;
      logic        ping_f;
      upkf_tx_e    tst;
      logic        tshort;
      logic [15:0] ttyp;
      logic [7:0]  tlen;
      logic [7:0]  tidx;
      logic [15:0] tcrc;
      logic        tbusy;
      logic [3:0]  tbit;
      logic [10:0] tcnt;
      logic [9:0]  tsh;
      logic        rx_done;
      logic [15:0] rx_type;
      logic [7:0]  rx_len;
      logic [7:0]  rd_data;
      logic        tx_busy;
   } upkf_dev_s;

   upkf_dev_s   q;
   upkf_dev_s   d;
   logic        rx_ok;
   logic        mem_we;
   logic [10:0] div;
   logic [15:0] gap_cyc;
   logic [7:0]  bt;
   logic [7:0]  pay_mem [256];

   always_comb begin
      d       = q;
      rx_ok   = 1'b0;
      mem_we  = 1'b0;
      bt      = PRE_BYTE;
      div     = upkf_div(q.baud);
      gap_cyc = 16'(div) * GAP_BITS;
      d.sync    = {q.sync[0], lnk.h2d};
      d.rx_done = 1'b0;
      d.rd_data = pay_mem[rd_addr];
      if (baud_ld) begin
         d.baud = baud_sel;
      end

      // receive character: mid-bit sampling of start, 8 data, stop
      if (!q.rbusy) begin
         if (!q.sync[1]) begin
            d.rbusy = 1'b1;
            d.rcnt  = {1'b0, div[10:1]};
            d.rbit  = 4'h0;
         end
      end else if (q.rcnt != 11'h000) begin
         d.rcnt = q.rcnt - 11'h001;
      end else begin
         d.rcnt = div - 11'h001;
         if (q.rbit == 4'h0 && q.sync[1]) begin
            d.rbusy = 1'b0; // glitch, not a start bit
         end else if (q.rbit == STOP_BIT) begin
            d.rbusy = 1'b0;
            rx_ok   = q.sync[1];
         end else begin
            if (q.rbit != 4'h0) begin
               d.rsh = {q.sync[1], q.rsh[7:1]};
            end
            d.rbit = q.rbit + 4'h1;
         end
      end

      // transmit sequencer; ping answers go ahead of user packets
      if (q.tst == TX_IDLE) begin
         d.tidx = 8'h00;
         if (q.ping_s) begin
            d.ping_s = 1'b0;
            d.tst    = TX_TYP1;
            d.tshort = 1'b1;
            d.ttyp   = PING_TYPE;
         end else if (q.ping_f) begin
            d.ping_f = 1'b0;
            d.tst    = TX_PRE1;
            d.tshort = 1'b0;
            d.ttyp   = PING_TYPE;
            d.tlen   = 8'h00;
         end else if (tx_req) begin
            d.tst    = TX_PRE1;
            d.tshort = 1'b0;
            d.ttyp   = tx_type;
            d.tlen   = tx_len;
         end
      end else if (!q.tbusy) begin
         case (q.tst)
            TX_TYP1: bt = q.ttyp[15:8];
            TX_TYP2: bt = q.ttyp[7:0];
            TX_LEN:  bt = q.tlen;
            TX_PAY:  bt = pl_byte;
            TX_CRC1: bt = q.tcrc[15:8];
            TX_CRC2: bt = q.tcrc[7:0];
            default: bt = PRE_BYTE;
         endcase
         d.tbusy = 1'b1;
         d.tsh   = {1'b1, bt, 1'b0};
         d.tcnt  = div - 11'h001;
         d.tbit  = 4'h0;
         if (q.tst == TX_TYP1) begin
            d.tcrc = upkf_crc(CRC_INIT, bt);
         end else if (q.tst == TX_TYP2 || q.tst == TX_LEN ||
                      q.tst == TX_PAY) begin
            d.tcrc = upkf_crc(q.tcrc, bt);
         end
         case (q.tst)
            TX_PRE1: d.tst = TX_PRE2;
            TX_PRE2: d.tst = TX_TYP1;
            TX_TYP1: d.tst = TX_TYP2;
            TX_TYP2: d.tst = q.tshort ? TX_IDLE : TX_LEN;
            TX_LEN:  d.tst = (q.tlen == 8'h00) ? TX_CRC1 : TX_PAY;
            TX_PAY: begin
               d.tidx = q.tidx + 8'h01;
               if (q.tidx == q.tlen - 8'h01) begin
                  d.tst = TX_CRC1;
               end
            end
            TX_CRC1: d.tst = TX_CRC2;
            default: d.tst = TX_IDLE;
         endcase
      end

      // transmit character
      if (q.tbusy) begin
         if (q.tcnt != 11'h000) begin
            d.tcnt = q.tcnt - 11'h001;
         end else begin
            d.tcnt = div - 11'h001;
            d.tsh  = {1'b1, q.tsh[9:1]};
            if (q.tbit == STOP_BIT) begin
               d.tbusy = 1'b0;
            end else begin
               d.tbit = q.tbit + 4'h1;
            end
         end
      end

      // packet parser; set of a ping flag here wins over its clear above
      d.gap = rx_ok ? 16'h0000 :
              (q.gap == 16'hFFFF) ? q.gap : q.gap + 16'h0001;
      d.tmo = (q.pst == RX_HUNT) ? 28'h0000000 : q.tmo + 28'h0000001;
      if (rx_ok) begin
         case (q.pst)
            RX_HUNT: begin
               if (q.rsh == PRE_BYTE) begin
                  d.pst = RX_PRE2;
               end
            end
            RX_PRE2: d.pst = (q.rsh == PRE_BYTE) ? RX_TYP1 : RX_HUNT;
            RX_TYP1: begin
               d.typ[15:8] = q.rsh;
               d.crc       = upkf_crc(CRC_INIT, q.rsh);
               d.pst       = RX_TYP2;
            end
            RX_TYP2: begin
               d.typ[7:0] = q.rsh;
               d.crc      = upkf_crc(q.crc, q.rsh);
               d.pst      = RX_LEN;
            end
            RX_LEN: begin
               d.len = q.rsh;
               d.idx = 8'h00;
               d.crc = upkf_crc(q.crc, q.rsh);
               d.pst = (q.rsh == 8'h00) ? RX_CRC1 : RX_PAY;
            end
            RX_PAY: begin
               mem_we = 1'b1;
               d.crc  = upkf_crc(q.crc, q.rsh);
               d.idx  = q.idx + 8'h01;
               if (q.idx == q.len - 8'h01) begin
                  d.pst = RX_CRC1;
               end
            end
            RX_CRC1: begin
               d.crc_hi = q.rsh;
               d.pst    = RX_CRC2;
            end
            RX_CRC2: begin
               d.pst = RX_HUNT;
               if ({q.crc_hi, q.rsh} == q.crc) begin
                  if (q.typ == PING_TYPE && q.len == 8'h00) begin
                     d.ping_f = 1'b1;
                  end else begin
                     d.rx_done = 1'b1;
                     d.rx_type = q.typ;
                     d.rx_len  = q.len;
                  end
               end
            end
            default: d.pst = RX_HUNT;
         endcase
      end else if (q.pst == RX_LEN && q.typ == PING_TYPE &&
                   q.gap >= gap_cyc && !q.rbusy) begin
         // a silent line after the type means a terminal ping
         d.ping_s = 1'b1;
         d.pst    = RX_HUNT;
      end
      if (q.pst != RX_HUNT && q.tmo >= 28'(TMO_CYC - 1)) begin
         d.pst = RX_HUNT;
      end
      d.tx_busy = (d.tst != TX_IDLE) || d.tbusy;
   end

   // payload store; a new packet overwrites it, so read before the next
   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         pay_mem[q.idx] <= q.rsh;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q      <= '0;
         q.baud <= BAUD_RST;
         q.sync <= SYNC_IDLE;
         q.tsh  <= LINE_IDLE;
      end else begin
         q <= d;
      end
   end

   assign lnk.d2h = q.tsh[0];
   assign rx_done = q.rx_done;
   assign rx_type = q.rx_type;
   assign rx_len  = q.rx_len;
   assign rd_data = q.rd_data;
   assign tx_busy = q.tx_busy;
   assign pl_idx  = q.tidx;
endmodule
`default_nettype wire

// file: logic/upkf_host.sv
// Purpose: host end of the uart packet framer
// Assumes: user logic on ref_clk; pl_byte answers pl_idx combinationally
// Notes:   received payload is streamed before its crc is known
`timescale 1ns/100ps
`default_nettype none
module upkf_host (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   // serial link
   upkf_if.host                      lnk,
   // line rate
   input  wire upkf_pkg::upkf_baud_e baud_sel,
   input  wire logic                 baud_ld,
   // commands to send
   input  wire logic                 cmd_req,
   input  wire logic                 cmd_short,
   input  wire logic [15:0]          cmd_type,
   input  wire logic [7:0]           cmd_len,
   output logic                      cmd_busy,
   output logic [7:0]                pl_idx,
   input  wire logic [7:0]           pl_byte,
   // replies
   output logic                      rsp_vld,
   output logic [7:0]                rsp_byte,
   output logic                      rsp_done,
   output logic                      rsp_crc_ok,
   output logic [15:0]               rsp_type,
   output logic [7:0]                rsp_len,
   output logic                      rsp_ping
);
   import upkf_pkg::*;

   typedef struct packed {
      logic [1:0]  sync;
      upkf_baud_e  baud;
      logic        rbusy;
      logic [3:0]  rbit;
      logic [10:0] rcnt;
      logic [7:0]  rsh;
      upkf_rx_e    pst;
      logic [7:0]  idx;
      logic [15:0] crc;
      logic [7:0]  crc_hi;
      upkf_tx_e    tst;
      logic        tshort;
      logic [15:0] ttyp;
      logic [7:0]  tlen;
      logic [7:0]  tidx;
      logic [15:0] tcrc;
      logic        tbusy;
      logic [3:0]  tbit;
      logic [10:0] tcnt;
      logic [9:0]  tsh;
      logic        cmd_busy;
      logic        rsp_vld;
      logic [7:0]  rsp_byte;
      logic        rsp_done;
      logic        rsp_crc_ok;
      logic [15:0] rsp_type;
      logic [7:0]  rsp_len;
      logic        rsp_ping;
   } upkf_host_s;

   upkf_host_s  q;
   upkf_host_s  d;
   logic        rx_ok;
   logic [10:0] div;
   logic [7:0]  bt;

   always_comb begin
      d     = q;
      rx_ok = 1'b0;
      bt    = PRE_BYTE;
      div   = upkf_div(q.baud);
      d.sync     = {q.sync[0], lnk.d2h};
      d.rsp_vld  = 1'b0;
      d.rsp_done = 1'b0;
      d.rsp_ping = 1'b0;
      if (baud_ld) begin
         d.baud = baud_sel;
      end

      if (!q.rbusy) begin
         if (!q.sync[1]) begin
            d.rbusy = 1'b1;
            d.rcnt  = {1'b0, div[10:1]};
            d.rbit  = 4'h0;
         end
      end else if (q.rcnt != 11'h000) begin
         d.rcnt = q.rcnt - 11'h001;
      end else begin
         d.rcnt = div - 11'h001;
         if (q.rbit == 4'h0 && q.sync[1]) begin
            d.rbusy = 1'b0;
         end else if (q.rbit == STOP_BIT) begin
            d.rbusy = 1'b0;
            rx_ok   = q.sync[1];
         end else begin
            if (q.rbit != 4'h0) begin
               d.rsh = {q.sync[1], q.rsh[7:1]};
            end
            d.rbit = q.rbit + 4'h1;
         end
      end

      // command sender keeps characters back to back within a packet
      if (q.tst == TX_IDLE) begin
         d.tidx = 8'h00;
         if (cmd_req) begin
            d.tst    = TX_PRE1;
            d.tshort = cmd_short;
            d.ttyp   = cmd_type;
            d.tlen   = cmd_len;
         end
      end else if (!q.tbusy) begin
         case (q.tst)
            TX_TYP1: bt = q.ttyp[15:8];
            TX_TYP2: bt = q.ttyp[7:0];
            TX_LEN:  bt = q.tlen;
            TX_PAY:  bt = pl_byte;
            TX_CRC1: bt = q.tcrc[15:8];
            TX_CRC2: bt = q.tcrc[7:0];
            default: bt = PRE_BYTE;
         endcase
         d.tbusy = 1'b1;
         d.tsh   = {1'b1, bt, 1'b0};
         d.tcnt  = div - 11'h001;
         d.tbit  = 4'h0;
         if (q.tst == TX_TYP1) begin
            d.tcrc = upkf_crc(CRC_INIT, bt);
         end else if (q.tst == TX_TYP2 || q.tst == TX_LEN ||
                      q.tst == TX_PAY) begin
            d.tcrc = upkf_crc(q.tcrc, bt);
         end
         case (q.tst)
            TX_PRE1: d.tst = TX_PRE2;
            TX_PRE2: d.tst = TX_TYP1;
            TX_TYP1: d.tst = TX_TYP2;
            TX_TYP2: d.tst = q.tshort ? TX_IDLE : TX_LEN;
            TX_LEN:  d.tst = (q.tlen == 8'h00) ? TX_CRC1 : TX_PAY;
            TX_PAY: begin
               d.tidx = q.tidx + 8'h01;
               if (q.tidx == q.tlen - 8'h01) begin
                  d.tst = TX_CRC1;
               end
            end
            TX_CRC1: d.tst = TX_CRC2;
            default: d.tst = TX_IDLE;
         endcase
      end

      if (q.tbusy) begin
         if (q.tcnt != 11'h000) begin
            d.tcnt = q.tcnt - 11'h001;
         end else begin
            d.tcnt = div - 11'h001;
            d.tsh  = {1'b1, q.tsh[9:1]};
            if (q.tbit == STOP_BIT) begin
               d.tbusy = 1'b0;
            end else begin
               d.tbit = q.tbit + 4'h1;
            end
         end
      end

      // reply parser; a bare ping type is the short ping answer
      if (rx_ok) begin
         case (q.pst)
            RX_HUNT: begin
               if (q.rsh == PRE_BYTE) begin
                  d.pst = RX_PRE2;
               end else if (q.rsh == PING_TYPE[15:8]) begin
                  d.pst = RX_PING_LO;
               end
            end
            RX_PING_LO: begin
               d.rsp_ping = (q.rsh == PING_TYPE[7:0]);
               d.pst      = RX_HUNT;
            end
            RX_PRE2: d.pst = (q.rsh == PRE_BYTE) ? RX_TYP1 : RX_HUNT;
            RX_TYP1: begin
               d.rsp_type[15:8] = q.rsh;
               d.crc            = upkf_crc(CRC_INIT, q.rsh);
               d.pst            = RX_TYP2;
            end
            RX_TYP2: begin
               d.rsp_type[7:0] = q.rsh;
               d.crc           = upkf_crc(q.crc, q.rsh);
               d.pst           = RX_LEN;
            end
            RX_LEN: begin
               d.rsp_len = q.rsh;
               d.idx     = 8'h00;
               d.crc     = upkf_crc(q.crc, q.rsh);
               d.pst     = (q.rsh == 8'h00) ? RX_CRC1 : RX_PAY;
            end
            RX_PAY: begin
               d.rsp_vld  = 1'b1;
               d.rsp_byte = q.rsh;
               d.crc      = upkf_crc(q.crc, q.rsh);
               d.idx      = q.idx + 8'h01;
               if (q.idx == q.rsp_len - 8'h01) begin
                  d.pst = RX_CRC1;
               end
            end
            RX_CRC1: begin
               d.crc_hi = q.rsh;
               d.pst    = RX_CRC2;
            end
            RX_CRC2: begin
               d.rsp_done   = 1'b1;
               d.rsp_crc_ok = ({q.crc_hi, q.rsh} == q.crc);
               d.pst        = RX_HUNT;
            end
            default: d.pst = RX_HUNT;
         endcase
      end
      d.cmd_busy = (d.tst != TX_IDLE) || d.tbusy;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q      <= '0;
         q.baud <= BAUD_RST;
         q.sync <= SYNC_IDLE;
         q.tsh  <= LINE_IDLE;
      end else begin
         q <= d;
      end
   end

   assign lnk.h2d    = q.tsh[0];
   assign cmd_busy   = q.cmd_busy;
   assign pl_idx     = q.tidx;
   assign rsp_vld    = q.rsp_vld;
   assign rsp_byte   = q.rsp_byte;
   assign rsp_done   = q.rsp_done;
   assign rsp_crc_ok = q.rsp_crc_ok;
   assign rsp_type   = q.rsp_type;
   assign rsp_len    = q.rsp_len;
   assign rsp_ping   = q.rsp_ping;
endmodule
`default_nettype wire

// file: testbench/upkf_assertions.sv
// Purpose: wire checks on the two serial lines
// Assumes: 230400 baud once traffic starts
// Notes:   run counters give line levels in cycles
`timescale 1ns/100ps
`default_nettype none
module upkf_assertions (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // serial lines
   input wire logic h2d,
   input wire logic d2h
);
   import upkf_pkg::*;
   localparam int DV = int'(DIV_230400);
   logic [19:0] hl_q, hh_q, dl_q, dh_q;
   logic        ask_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // wide counters: idle gaps run far past one frame
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {hl_q, hh_q, dl_q, dh_q, ask_q} <= '0;
      end else begin
         hl_q  <= h2d ? '0 : hl_q + 1'b1;
         hh_q  <= h2d ? hh_q + 1'b1 : '0;
         dl_q  <= d2h ? '0 : dl_q + 1'b1;
         dh_q  <= d2h ? dh_q + 1'b1 : '0;
         ask_q <= ask_q | !h2d;
      end
   end
   a_idle_after_rst: assert property (
      $fell(sys_rst) |-> (h2d && d2h) [*2]) else $error("line busy");
   a_h2d_bit_len: assert property (
      $rose(h2d) |-> (hl_q % DV) == 0) else $error("h2d low run");
   a_d2h_bit_len: assert property (
      $rose(d2h) |-> (dl_q % DV) == 0) else $error("d2h low run");
   a_h2d_stop_bit: assert property (
      hl_q <= 9 * DV) else $error("h2d stop missing");
   a_d2h_stop_bit: assert property (
      dl_q <= 9 * DV) else $error("d2h stop missing");
   a_h2d_gap_min: assert property (
      $fell(h2d) |-> hh_q >= DV) else $error("h2d high short");
   a_d2h_gap_min: assert property (
      $fell(d2h) |-> dh_q >= DV) else $error("d2h high short");
   a_no_unasked: assert property (
      !ask_q |-> d2h) else $error("device spoke first");
   c_reply: cover property ($fell(d2h));
   c_frame: cover property ($rose(h2d) && hl_q == 20'(DV));
   c_ask: cover property ($rose(ask_q));
endmodule
`default_nettype wire

// file: testbench/upkf_tb_top.sv
// Purpose: host and device ends joined, plus a device fed raw bytes
// Assumes: 230400 baud after start-up, short device timeout
// Notes:   raw bytes break the crc and the timeout on purpose
`timescale 1ns/100ps
`default_nettype none
module upkf_tb_top;
   import upkf_pkg::*;
   localparam int DV = int'(DIV_230400);
   logic        ref_clk, sys_rst, baud_ld, rx_done, rx_done2, got2;
   logic        tx_req, cmd_req, cmd_short, rsp_vld, rsp_done;
   logic        rsp_crc_ok, rsp_ping;
   logic        tx_busy, cmd_busy;
   logic [15:0] rx_type, rx_type2, tx_type, cmd_type, rsp_type;
   logic [7:0]  rx_len, rd_addr, rd_data, tx_len, cmd_len, rsp_byte;
   logic [7:0]  d_idx, h_idx, rsp_len;
   logic [7:0]  pay [4];
   upkf_baud_e  baud_sel;
   int          n_fail, cmp_count;
   upkf_if lnk ();
   upkf_if lnk2 ();
   upkf_dev #(.TMO_CYC(14000)) u_upkf_dev (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .lnk(lnk.dev), .baud_sel(baud_sel),
      .baud_ld(baud_ld), .rx_done(rx_done), .rx_type(rx_type),
      .rx_len(rx_len), .rd_addr(rd_addr), .rd_data(rd_data),
      .tx_req(tx_req), .tx_type(tx_type), .tx_len(tx_len), .tx_busy(tx_busy),
      .pl_idx(d_idx), .pl_byte(pay[d_idx[1:0]]));
   upkf_dev #(.TMO_CYC(14000)) u_upkf_dev_flt (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .lnk(lnk2.dev), .baud_sel(baud_sel),
      .baud_ld(baud_ld), .rx_done(rx_done2), .rx_type(rx_type2),
      .rx_len(), .rd_addr(rd_addr), .rd_data(), .tx_req(1'b0),
      .tx_type(tx_type), .tx_len(tx_len), .tx_busy(), .pl_idx(),
      .pl_byte(8'h00));
   upkf_host u_upkf_host (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .lnk(lnk.host), .baud_sel(baud_sel), .baud_ld(baud_ld),
      .cmd_req(cmd_req), .cmd_short(cmd_short), .cmd_type(cmd_type),
      .cmd_len(cmd_len), .cmd_busy(cmd_busy), .pl_idx(h_idx),
      .pl_byte(pay[h_idx[1:0]]), .rsp_vld(rsp_vld), .rsp_byte(rsp_byte),
      .rsp_done(rsp_done), .rsp_crc_ok(rsp_crc_ok), .rsp_type(rsp_type),
      .rsp_len(rsp_len), .rsp_ping(rsp_ping));
   upkf_assertions u_upkf_assertions (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .h2d(lnk.h2d), .d2h(lnk.d2h));
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // bit-serial crc, kept apart from the byte-wise form of the design
   function automatic logic [15:0] tcrc(logic [15:0] c, logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction
   task automatic host_cmd(logic s, logic [15:0] t, logic [7:0] l,
                           logic [23:0] p);
      @(posedge ref_clk);
      {pay[0], pay[1], pay[2]} <= p;
      cmd_short <= s;
      cmd_type  <= t;
      cmd_len   <= l;
      cmd_req   <= 1'b1;
      @(posedge ref_clk);
      cmd_req   <= 1'b0;
      @(negedge ref_clk);
      check("cmd_busy", cmd_busy, 1'b1);
   endtask
   task automatic raw_pkt(logic [15:0] x, int n);
      logic [7:0]  b [7];
      logic [15:0] c;
      logic [9:0]  f;
      c = tcrc(tcrc(tcrc(16'hFFFF, 8'h43), 8'h48), 8'h00) ^ x;
      b = '{8'h55, 8'h55, 8'h43, 8'h48, 8'h00, c[15:8], c[7:0]};
      @(posedge ref_clk);
      got2 <= 1'b0;
      for (int i = 0; i < n; i++) begin
         f = {1'b1, b[i], 1'b0};
         for (int k = 0; k < 10; k++) begin
            lnk2.h2d <= f[k];
            repeat (DV) @(posedge ref_clk);
         end
      end
   endtask
   // any reply on the raw link also counts as a reaction
   always @(posedge ref_clk) begin
      if (rx_done2 === 1'b1 || lnk2.d2h !== 1'b1) got2 <= 1'b1;
   end
   task automatic s_cmd();
      int i;
      host_cmd(1'b0, 16'h4348, 8'h02, 24'hA1B200);
      for (i = 0; i < 20000 && rx_done !== 1'b1; i++) @(negedge ref_clk);
      check("rx_type", rx_type, 16'h4348);
      check("rx_len", rx_len, 8'h02);
      for (i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         rd_addr <= i[7:0];
         repeat (2) @(negedge ref_clk);
         check("rd_data", rd_data, pay[i]);
      end
   endtask
   task automatic s_bad();
      raw_pkt(16'h0001, 7);
      repeat (200) @(negedge ref_clk);
      check("rx_done2", got2, 1'b0);
   endtask
   task automatic s_ping();
      logic seen;
      seen = 1'b0;
      host_cmd(1'b0, 16'h504B, 8'h00, 24'h000000);
      for (int i = 0; i < 30000 && rsp_done !== 1'b1; i++) begin
         @(negedge ref_clk);
         seen |= rx_done;
      end
      check("rsp_crc_ok", rsp_crc_ok, 1'b1);
      check("rsp_type", rsp_type, 16'h504B);
      check("rx_on_ping", seen, 1'b0);
      host_cmd(1'b1, 16'h504B, 8'h00, 24'h000000);
      for (int i = 0; i < 20000 && rsp_ping !== 1'b1; i++) @(negedge ref_clk);
      check("rsp_ping", rsp_ping, 1'b1);
   endtask
   task automatic s_dev_tx();
      int k;
      k = 0;
      @(posedge ref_clk);
      {pay[0], pay[1], pay[2]} <= 24'h112233;
      tx_type <= 16'h5652;
      tx_len  <= 8'h03;
      tx_req  <= 1'b1;
      @(posedge ref_clk);
      tx_req  <= 1'b0;
      @(negedge ref_clk);
      check("tx_busy", tx_busy, 1'b1);
      for (int i = 0; i < 20000 && rsp_done !== 1'b1; i++) begin
         @(negedge ref_clk);
         if (rsp_vld === 1'b1) begin
            check("rsp_byte", rsp_byte, pay[k[1:0]]);
            k++;
         end
      end
      check("rsp_count", k, 3);
      check("rsp_crc_ok", rsp_crc_ok, 1'b1);
      check("rsp_type", rsp_type, 16'h5652);
      check("rsp_len", rsp_len, 8'h03);
   endtask
   task automatic s_tmo();
      raw_pkt(16'h0000, 3);
      repeat (16000) @(posedge ref_clk);
      raw_pkt(16'h0000, 7);
      repeat (200) @(negedge ref_clk);
      check("rx_done2", got2, 1'b1);
      check("rx_type2", rx_type2, 16'h4348);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (90000) @(posedge ref_clk);
      n_fail++;
      complete_run();
   end
   initial begin
      sys_rst   = 1'b1;
      baud_sel  = UPKF_B115200;
      baud_ld   = 1'b0;
      rd_addr   = 8'h00;
      tx_req    = 1'b0;
      tx_type   = 16'h0000;
      tx_len    = 8'h00;
      cmd_req   = 1'b0;
      cmd_short = 1'b0;
      cmd_type  = 16'h0000;
      cmd_len   = 8'h00;
      pay       = '{default: 8'h00};
      lnk2.h2d  = 1'b1;
      got2      = 1'b0;
      n_fail    = 0;
      cmp_count = 0;
      repeat (10) @(posedge ref_clk);
      sys_rst  <= 1'b0;
      @(posedge ref_clk);
      baud_sel <= UPKF_B230400;
      baud_ld  <= 1'b1;
      @(posedge ref_clk);
      baud_ld  <= 1'b0;
      repeat (400) @(posedge ref_clk);
      fork
         s_cmd();
         s_bad();
      join
      fork
         s_ping();
         s_tmo();
      join
      s_dev_tx();
      complete_run();
   end
endmodule
`default_nettype wire
